// ===== kms_defs.svh
// Offsets, field positions, reset values and timing counts of the key scanner
`ifndef KMS_DEFS_SVH
`define KMS_DEFS_SVH

// Register byte offsets
`define KMS_OFS_CTRL     8'h00
`define KMS_OFS_GPO      8'h04
`define KMS_OFS_KEY      8'h08
`define KMS_OFS_STATUS   8'h0C

// Field positions
`define KMS_CTRL_SLEEP_LSB  0
`define KMS_CTRL_PFN_LSB    3
`define KMS_KEY_ACK_BIT     30
`define KMS_ST_REQ_BIT      0
`define KMS_ST_PSAVE_BIT    1
`define KMS_ST_STATE_LSB    2

// Reset values
`define KMS_CTRL_RESET   6'h00
`define KMS_GPO_RESET    9'h000

// Matrix shape
`define KMS_ROWS         6
`define KMS_COLS         5
`define KMS_KEYS         30

// Timing in oscillator periods
`define KMS_SCAN_T       4608
`define KMS_REQ_T        9840
`define KMS_RESCAN_T     19680

`endif

// ===== kms_pkg.sv
// Types of the key scanner
`default_nettype none
package kms_pkg;

    typedef enum logic [1:0] {
        KMS_IDLE = 2'b00,
        KMS_SCAN = 2'b01,
        KMS_WAIT = 2'b10,
        KMS_REQ  = 2'b11
    } kms_state_t;

    typedef struct packed {
        logic [2:0] port_fn;
        logic [2:0] sleep_sel;
    } kms_ctrl_t;

    typedef struct packed {
        logic        ack;
        logic [29:0] keys;
    } kms_keyword_t;

endpackage
`default_nettype wire

// ===== kms_key_scan.sv
// Key matrix scanner with power saving and Wishbone register access
// Notes on behaviour
// - Key read data carries power-save ack: 1 in power save, 0 normal.
// - Any sleep-select bit set enters power save; all clear leaves it.
// - Power save forces segment and common outputs low, stops oscillator once scanner is idle.
// - Multi-function outputs keep general-purpose function in power save.
// - One scan pass lasts 4608 oscillator periods.
// - Two matching scans accepted; request raised 9840 periods after start.
// - Mismatch with key still pressed repeats scan; one repeat gives 19056.
// - Normal idle holds all scan lines high; scan until keys released.
// - Simultaneous presses set every matching key bit.
// - Request pulls data out low; released while serial select high.
// - Completed key read clears request and starts another scan.
// - Key read in power save leaves power save unchanged.
// - Power save holds scan lines per sleep bits; low lines never scan.
// - Press on a high line in power save restarts oscillator, scans.
// - Request output is open-drain, drives only low.
// - Key bit index is five times row plus zero-based sense line.
`timescale 1ns/1ps
`default_nettype none
`include "kms_defs.svh"

module kms_key_scan #(
    parameter int SCAN_T   = `KMS_SCAN_T,
    parameter int REQ_T    = `KMS_REQ_T
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Oscillator and serial select pins
    input  wire logic        oscillator_pin_i,
    input  wire logic        serial_select_i,
    // Key matrix
    output logic      [5:0]  scan_drive_o,
    input  wire logic [4:0]  sense_i,
    // Open-drain read request
    output logic             request_data_out_o,
    output logic             request_data_out_oe_o,
    // Display side controls
    output logic             seg_com_low_o,
    output logic             osc_run_o,
    output logic      [8:0]  multi_function_o
);

    localparam int SLOT_T = SCAN_T / `KMS_ROWS;
    localparam logic [13:0] REQ_LAST  = 14'(REQ_T - 1);
    localparam logic [9:0]  SLOT_LAST = 10'(SLOT_T - 1);
    localparam logic [2:0]  ROW_LAST  = 3'(`KMS_ROWS - 1);

    ////////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [1:0] reg_index(input logic [7:0] adr);
        reg_index = adr[3:2];
    endfunction

    // Scan lines kept high in power save
    function automatic logic [5:0] ps_lines(input logic [2:0] s);
        ps_lines = {s[2], s[1], s[0], s[0], s[0], s[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [4:0] sense_m_q;
    logic [4:0] sense_s_q;
    logic       sel_m_q;
    logic       sel_s_q;
    logic       osc_m_q;
    logic       osc_s_q;
    logic       osc_d_q;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sense_m_q <= 5'h00;
            sense_s_q <= 5'h00;
            sel_m_q   <= 1'b0;
            sel_s_q   <= 1'b0;
            osc_m_q   <= 1'b0;
            osc_s_q   <= 1'b0;
            osc_d_q   <= 1'b0;
        end
        else
        begin
            sense_m_q <= sense_i;
            sense_s_q <= sense_m_q;
            sel_m_q   <= serial_select_i;
            sel_s_q   <= sel_m_q;
            osc_m_q   <= oscillator_pin_i;
            osc_s_q   <= osc_m_q;
            osc_d_q   <= osc_s_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers and bus

    kms_pkg::kms_ctrl_t    ctrl_q;
    logic [8:0]            gpo_q;
    kms_pkg::kms_keyword_t key_q;
    kms_pkg::kms_state_t   state_q;
    logic                  req_q;
    logic                  psave;
    logic                  tick;
    logic                  bus_done;
    logic                  key_read;

    assign psave    = |ctrl_q.sleep_sel;
    assign bus_done = wb_cyc_i & wb_stb_i & wb_ack_o;
    assign key_read = bus_done & ~wb_we_i
                      & (reg_index(wb_adr_i) == reg_index(`KMS_OFS_KEY));
    assign tick     = osc_s_q & ~osc_d_q & osc_run_o;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end

    // Writes take effect at the acknowledging edge
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= `KMS_CTRL_RESET;
            gpo_q  <= `KMS_GPO_RESET;
        end
        else if (bus_done && wb_we_i)
        begin
            if (reg_index(wb_adr_i) == reg_index(`KMS_OFS_CTRL) && wb_sel_i[0])
                ctrl_q <= wb_dat_i[5:0];
            if (reg_index(wb_adr_i) == reg_index(`KMS_OFS_GPO) && wb_sel_i[0])
                gpo_q[7:0] <= wb_dat_i[7:0];
            if (reg_index(wb_adr_i) == reg_index(`KMS_OFS_GPO) && wb_sel_i[1])
                gpo_q[8] <= wb_dat_i[8];
        end
    end

    // Read data captured with the request
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wb_dat_o <= 32'h0000_0000;
        else if (wb_cyc_i && wb_stb_i && !wb_ack_o)
        begin
            unique case (reg_index(wb_adr_i))
                2'h0: wb_dat_o <= {26'h0, ctrl_q};
                2'h1: wb_dat_o <= {23'h0, gpo_q};
                2'h2: wb_dat_o <= {1'b0, key_q};
                2'h3: wb_dat_o <= {28'h0, state_q, psave, req_q};
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Scan engine

    logic [13:0] elapsed_q;
    logic [9:0]  slot_q;
    logic [2:0]  row_q;
    logic        pass_q;
    logic [29:0] word_a_q;
    logic [29:0] word_b_q;
    logic [29:0] word_b_d;
    logic        pressed;
    logic        pass_end;

    assign pressed  = |sense_s_q;
    assign pass_end = tick && slot_q == SLOT_LAST && row_q == ROW_LAST;

    // Last row of the second pass folded in for the compare
    always_comb
    begin
        word_b_d = word_b_q;
        word_b_d[row_q * 5 +: 5] = sense_s_q;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            elapsed_q <= 14'h0000;
            slot_q    <= 10'h000;
            row_q     <= 3'h0;
            pass_q    <= 1'b0;
            word_a_q  <= 30'h0;
            word_b_q  <= 30'h0;
        end
        else if (state_q != kms_pkg::KMS_SCAN)
        begin
            slot_q <= 10'h000;
            row_q  <= 3'h0;
            pass_q <= 1'b0;
            if (state_q == kms_pkg::KMS_WAIT && tick)
                elapsed_q <= elapsed_q + 14'h0001;
            else if (state_q != kms_pkg::KMS_WAIT)
                elapsed_q <= 14'h0000;
        end
        else if (tick)
        begin
            elapsed_q <= elapsed_q + 14'h0001;
            slot_q    <= slot_q + 10'h001;
            if (slot_q == SLOT_LAST)
            begin
                slot_q <= 10'h000;
                if (pass_q)
                    word_b_q[row_q * 5 +: 5] <= sense_s_q;
                else
                    word_a_q[row_q * 5 +: 5] <= sense_s_q;
                row_q <= row_q + 3'h1;
                if (row_q == ROW_LAST)
                begin
                    row_q  <= 3'h0;
                    pass_q <= ~pass_q;
                    if (pass_q && word_b_d != word_a_q)
                        elapsed_q <= 14'h0000;
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_q <= kms_pkg::KMS_IDLE;
            key_q   <= 31'h0;
            req_q   <= 1'b0;
        end
        else
        begin
            key_q.ack <= psave;
            unique case (state_q)
                kms_pkg::KMS_IDLE:
                begin
                    if (pressed)
                    begin
                        state_q <= kms_pkg::KMS_SCAN;
                    end
                end
                kms_pkg::KMS_SCAN:
                begin
                    if (pass_end && pass_q)
                    begin
                        if (word_b_d == word_a_q)
                        begin
                            key_q.keys <= word_b_d;
                            state_q    <= (word_b_d == 30'h0)
                                          ? kms_pkg::KMS_IDLE
                                          : kms_pkg::KMS_WAIT;
                        end
                        else if (word_b_d == 30'h0)
                        begin
                            state_q <= kms_pkg::KMS_IDLE;
                        end
                    end
                end
                kms_pkg::KMS_WAIT:
                begin
                    if (tick && elapsed_q >= REQ_LAST)
                    begin
                        state_q <= kms_pkg::KMS_REQ;
                        req_q   <= 1'b1;
                    end
                end
                kms_pkg::KMS_REQ:
                begin
                    if (key_read)
                    begin
                        req_q   <= 1'b0;
                        state_q <= kms_pkg::KMS_SCAN;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            scan_drive_o          <= 6'h3F;
            request_data_out_o    <= 1'b0;
            request_data_out_oe_o <= 1'b0;
            seg_com_low_o         <= 1'b0;
            osc_run_o             <= 1'b1;
            multi_function_o      <= 9'h000;
        end
        else
        begin
            if (state_q == kms_pkg::KMS_SCAN)
            begin
                scan_drive_o <= (6'h01 << row_q)
                                & (psave ? ps_lines(ctrl_q.sleep_sel)
                                         : 6'h3F);
            end
            else
            begin
                scan_drive_o <= psave ? ps_lines(ctrl_q.sleep_sel)
                                      : 6'h3F;
            end
            request_data_out_o    <= 1'b0;
            request_data_out_oe_o <= req_q & ~sel_s_q;
            seg_com_low_o         <= psave;
            osc_run_o             <= ~psave
                                     | (state_q != kms_pkg::KMS_IDLE)
                                     | pressed;
            multi_function_o      <= (ctrl_q.port_fn != 3'h0)
                                     ? gpo_q : 9'h000;
        end
    end

endmodule

`default_nettype wire

// ===== kms_matrix_model.sv
// Key matrix and pull-up seen from the scanner pins
`timescale 1ns/1ps
`default_nettype none
module kms_matrix_model (
    // Pressed keys and scan lines
    input  wire logic [29:0] pressed_i,
    input  wire logic [5:0]  scan_drive_i,
    output logic      [4:0]  sense_o,
    // Open-drain request line
    input  wire logic        req_oe_i,
    output logic             req_line_o
);
    // A pressed key joins its scan line to its sense line
    always_comb
    begin
        sense_o = 5'h00;
        for (int r = 0; r < 6; r++)
            if (scan_drive_i[r])
                sense_o = sense_o | pressed_i[5*r +: 5];
    end
    // Pull-up gives the high level when nobody drives
    assign req_line_o = req_oe_i ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// ===== kms_key_scan_monitor.sv
// Port checker of the key scanner
`timescale 1ns/1ps
`default_nettype none
module kms_key_scan_monitor (
    // Clock, reset, bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Pins
    input wire logic        serial_select_i,
    input wire logic [5:0]  scan_drive_o,
    input wire logic        request_data_out_o,
    input wire logic        request_data_out_oe_o,
    input wire logic        seg_com_low_o,
    input wire logic        osc_run_o
);
    logic [2:0] slp_q;
    logic [1:0] age_q;
    wire logic  wr_w = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    wire logic  rk_w = wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h2;
    wire logic  ok_w = age_q == 2'h3;
    wire logic  ps_w = slp_q != 3'h0;

    // Shadow of sleep select
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            slp_q <= 3'h0;
        else if (wr_w && wb_adr_i[3:2] == 2'h0 && wb_sel_i[0])
            slp_q <= wb_dat_i[2:0];
    end
    // Cycles since last write
    always_ff @(posedge clk_i)
    begin
        if (rst_i || wr_w)
            age_q <= 2'h0;
        else if (!ok_w)
            age_q <= age_q + 2'h1;
    end
    ////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_ack_late: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_od_low: assert property (!request_data_out_o)
        else $error("request pin driven high");
    chk_sel_release: assert property (
        serial_select_i [*6] |-> !request_data_out_oe_o)
        else $error("request held while select high");
    chk_read_clear: assert property (
        rk_w && request_data_out_oe_o |-> ##[1:4] !request_data_out_oe_o)
        else $error("request not cleared by key read");
    chk_mode_out: assert property (
        ok_w |-> seg_com_low_o == ps_w)
        else $error("power save state wrong");
    chk_osc_stop: assert property (!osc_run_o |-> seg_com_low_o)
        else $error("oscillator stopped outside power save");
    chk_ack_bit: assert property (
        rk_w && ok_w |-> wb_dat_o[30] == ps_w)
        else $error("power save ack bit wrong");
    chk_ps_lines: assert property (
        ok_w && !osc_run_o |->
        scan_drive_o == {slp_q[2], slp_q[1], {4{slp_q[0]}}})
        else $error("power save scan lines wrong");
    chk_one_line: assert property (
        seg_com_low_o || scan_drive_o == 6'h3F || $onehot(scan_drive_o))
        else $error("more than one scan line active");
endmodule

bind kms_key_scan kms_key_scan_monitor kms_key_scan_monitor_i (.*);
`default_nettype wire

// ===== kms_key_scan_test.sv
// Self-checking bench of the key scanner
`timescale 1ns/1ps
`default_nettype none
module kms_key_scan_test;
    localparam int ST = 60;
    localparam int RT = 130;
    localparam int TK = 12;
    localparam int LO = (RT - 1) * TK;
    localparam int HI = (RT + 2) * TK;
    logic        clk_i, rst_i, cyc, stb, we, osc, ssel, ack, oe, od;
    logic        segl, orun, line;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat, rdat, q;
    logic [29:0] keys;
    logic [5:0]  scan;
    logic [4:0]  sense;
    logic [8:0]  mf;
    logic [2:0]  c;
    int          errors, samples_checked, n;

    kms_key_scan #(.SCAN_T(ST), .REQ_T(RT)) kms_key_scan_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .oscillator_pin_i(osc),
        .serial_select_i(ssel), .scan_drive_o(scan), .sense_i(sense),
        .request_data_out_o(od), .request_data_out_oe_o(oe),
        .seg_com_low_o(segl), .osc_run_o(orun), .multi_function_o(mf));
    kms_matrix_model kms_matrix_model_i (.pressed_i(keys),
        .scan_drive_i(scan), .sense_o(sense), .req_oe_i(oe),
        .req_line_o(line));

    initial
    begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial
    begin
        osc = 1'b0;
        forever #24 osc = ~osc;
    end
    ////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] s,
                         input logic [31:0] e);
        samples_checked++;
        if (s !== e)
        begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic results;
        if (errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        sel <= 4'hF;
        adr <= a;
        dat <= d;
        k = 0;
        @(posedge clk_i);
        while (ack !== 1'b1 && k < 20)
        begin
            k++;
            @(posedge clk_i);
        end
        if (ack !== 1'b1)
        begin
            errors++;
            results();
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wait_line(input int lim);
        for (n = 0; n < lim && line !== 1'b0; n++)
            @(negedge clk_i);
        if (n == lim)
        begin
            errors++;
            results();
        end
        @(posedge clk_i);
    endtask

    task automatic tick(input int m);
        repeat (m) @(posedge clk_i);
    endtask
    ////////////////////////////////////////////////////////////
    initial
    begin
        rst_i = 1'b1;
        {cyc, stb, we, ssel} = 4'h0;
        adr = 8'h00;
        sel = 4'hF;
        dat = 32'h0;
        keys = 30'h0;
        errors = 0;
        samples_checked = 0;
        tick(16);
        rst_i <= 1'b0;
        check("rst_out", {od, line, scan}, 32'h7F);
        bus(1'b1, 8'h0C, 32'hFFFF_FFFF);
        bus(1'b0, 8'h0C, 32'h0);
        check("status", q, 32'h0);
        bus(1'b1, 8'h04, 32'h1FF);
        bus(1'b1, 8'h00, 32'h08);
        tick(4);
        check("gpo", mf, 32'h1FF);
        keys <= 30'h2000_2000;
        wait_line(RT * TK * 2);
        check("t_req", 32'(n > LO && n < HI), 32'h1);
        ssel <= 1'b1;
        tick(8);
        check("sel_hi", line, 32'h1);
        ssel <= 1'b0;
        wait_line(20);
        bus(1'b0, 8'h08, 32'h0);
        check("key", q, 32'h2000_2000);
        check("key_cnt", 32'($countones(q[29:0]) < 3), 32'h1);
        tick(4);
        check("clr", line, 32'h1);
        wait_line(RT * TK * 2);
        keys <= 30'h0;
        bus(1'b0, 8'h08, 32'h0);
        tick(3 * ST * TK);
        check("idle", {line, scan}, 32'h7F);
        keys <= 30'h1;
        tick((ST + 5) * TK);
        keys <= 30'h80;
        wait_line(RT * TK * 2);
        check("t_re", 32'(n > (RT - ST) * TK), 32'h1);
        keys <= 30'h0;
        bus(1'b0, 8'h08, 32'h0);
        check("key_re", q, 32'h80);
        tick(3 * ST * TK);
        for (int i = 0; i < 3; i++)
        begin
            c = 3'(1 << i);
            bus(1'b1, 8'h00, {26'h0, 3'h1, c});
            tick(4);
            check("ps_lines", scan, {26'h0, c[2], c[1], {4{c[0]}}});
            check("ps_out", {segl, orun, mf}, 32'h5FF);
            bus(1'b0, 8'h0C, 32'h0);
            check("ps_st", q[1], 32'h1);
        end
        keys <= 30'h1;
        tick(RT * TK);
        check("ps_low", {orun, line}, 32'h1);
        keys <= 30'h0800_0000;
        wait_line(RT * TK * 2);
        keys <= 30'h0;
        bus(1'b0, 8'h08, 32'h0);
        check("ps_key", q, 32'h4800_0000);
        tick(3 * ST * TK);
        check("ps_keep", segl, 32'h1);
        bus(1'b1, 8'h00, 32'h0);
        tick(4);
        check("normal", {segl, orun, mf}, 32'h200);
        results();
    end
endmodule
`default_nettype wire
